// ### rtl/urm_serial_sig.sv
// Top of the dual-channel ready, send request and ring status logic
`timescale 1ns/1ns
`default_nettype none
module urm_serial_sig #(
  parameter int DATA_W = 8
) (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic [urm_pkg::ADR_W-1:0] addr,
  input  wire logic [DATA_W-1:0]       wr_data,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  output logic [DATA_W-1:0]            rd_data,
  input  wire logic                    ring_in_ch0,
  input  wire logic                    ring_in_ch1,
  input  wire urm_pkg::urm_rx_side_type rx_side_ch0,
  input  wire urm_pkg::urm_rx_side_type rx_side_ch1,
  output logic                         send_request_ch0_n,
  output logic                         send_request_ch1_n,
  output logic                         rx_dma_ready_ch0_n,
  output logic                         rx_dma_ready_ch1_n,
  output logic                         serial_irq_ch0,
  output logic                         serial_irq_ch1,
  output logic                         irq
);
  import urm_pkg::*;

  // Registers are a byte wide; a narrower bus cannot carry them
  if (DATA_W < REG_W) begin : g_bad_width
    $error("DATA_W must be at least REG_W");
  end

  urm_mctl_type      mctl_r   [NUM_CH];
  urm_fcr_type       fcr_r    [NUM_CH];
  urm_ier_type       ier_r    [NUM_CH];
  logic              rts_n_r  [NUM_CH];
  logic              sirq_r   [NUM_CH];
  logic              ring_lvl [NUM_CH];
  logic              ring_edge[NUM_CH];
  logic              ring_rise[NUM_CH];
  logic              rdy_n    [NUM_CH];
  logic              rdy_act  [NUM_CH];
  logic              ring_in  [NUM_CH];
  urm_rx_side_type   rx_side  [NUM_CH];
  logic [IRQ_W-1:0]  irq_sts_r;
  logic [IRQ_W-1:0]  irq_msk_r;
  logic [IRQ_W-1:0]  irq_ev;
  logic [DATA_W-1:0] rd_data_r;
  logic              irq_r;

  // Named pins onto channel arrays
  assign ring_in[0] = ring_in_ch0;
  assign ring_in[1] = ring_in_ch1;
  assign rx_side[0] = rx_side_ch0;
  assign rx_side[1] = rx_side_ch1;

  // Every output comes from a flop
  assign send_request_ch0_n = rts_n_r[0];
  assign send_request_ch1_n = rts_n_r[1];
  assign rx_dma_ready_ch0_n = rdy_n[0];
  assign rx_dma_ready_ch1_n = rdy_n[1];
  assign serial_irq_ch0     = sirq_r[0];
  assign serial_irq_ch1     = sirq_r[1];
  assign rd_data            = rd_data_r;
  assign irq                = irq_r;

  // One copy of the channel logic per channel, nothing shared
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch

    // Control register writes, decoded per channel
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        mctl_r[i] <= MCTL_RST;
        fcr_r[i] <= FCR_RST;
        ier_r[i] <= IER_RST;
      end else if (wr_en) begin
        if (addr == OFS_MCTL[i]) begin
          mctl_r[i] <= urm_mctl_type'(wr_data[REG_W-1:0]);
        end
        if (addr == OFS_FCR[i]) begin
          fcr_r[i] <= urm_fcr_type'(wr_data[REG_W-1:0]);
        end
        if (addr == OFS_IER[i]) begin
          ier_r[i] <= urm_ier_type'(wr_data[REG_W-1:0]);
        end
      end
    end

    // Ring level and edge flag; a status read clears the flag
    urm_ring_det u_ring (
      .clk        (clk),
      .nrst       (nrst),
      .ring_in    (ring_in[i]),
      .status_rd  (rd_en && (addr == OFS_MSTS[i])),
      .ring_lvl_r (ring_lvl[i]),
      .edge_flag_r(ring_edge[i]),
      .rise_r     (ring_rise[i])
    );

    // Receive DMA ready
    urm_rx_ready u_rdy (
      .clk          (clk),
      .nrst         (nrst),
      .fifo_en      (fcr_r[i].fifo_en),
      .dma_mode     (fcr_r[i].dma_mode),
      .rx_empty     (rx_side[i].rx_empty),
      .trig_hit     (rx_side[i].trig_hit),
      .timeout      (rx_side[i].timeout),
      .rdy_n_r      (rdy_n[i]),
      .went_active_r(rdy_act[i])
    );

    // Send request: software bit, loopback and threshold override
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        rts_n_r[i] <= 1'b1;
      end else begin
        rts_n_r[i] <= ~mctl_r[i].rts | mctl_r[i].loop
                      | (mctl_r[i].auto_rts & rx_side[i].thresh_hit);
      end
    end

    // Channel interrupt from enabled sources, modem change via edge flag
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        sirq_r[i] <= 1'b0;
      end else begin
        sirq_r[i] <= (ier_r[i].rx_data  & rx_side[i].data_avail)
                   | (ier_r[i].tx_empty & rx_side[i].thr_empty)
                   | (ier_r[i].line_st  & rx_side[i].rx_error)
                   | (ier_r[i].modem_st & ring_edge[i]);
      end
    end

    assign irq_ev[IRQ_RING_POS + i] = ring_rise[i];
    assign irq_ev[IRQ_RDY_POS + i]  = rdy_act[i];
  end

  // Sticky status: write one to clear, a new event in the same cycle wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_sts_r <= IRQ_RST;
    end else if (wr_en && (addr == OFS_IRQ_STS)) begin
      irq_sts_r <= irq_ev | (irq_sts_r & ~wr_data[IRQ_W-1:0]);
    end else begin
      irq_sts_r <= irq_ev | irq_sts_r;
    end
  end

  // Interrupt mask
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_msk_r <= IRQ_RST;
    end else if (wr_en && (addr == OFS_IRQ_MSK)) begin
      irq_msk_r <= wr_data[IRQ_W-1:0];
    end
  end

  // Level interrupt; one cycle behind status to keep the output on a flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_sts_r & irq_msk_r);
    end
  end

  // Read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= '0;
      if (rd_en) begin
        for (int c = 0; c < NUM_CH; c++) begin
          if (addr == OFS_MCTL[c]) begin
            rd_data_r <= DATA_W'(mctl_r[c]);
          end
          if (addr == OFS_FCR[c]) begin
            rd_data_r <= DATA_W'(fcr_r[c]);
          end
          if (addr == OFS_IER[c]) begin
            rd_data_r <= DATA_W'(ier_r[c]);
          end
          if (addr == OFS_MSTS[c]) begin
            rd_data_r                 <= '0;
            rd_data_r[MSTS_RING_BIT]  <= ring_lvl[c];
            rd_data_r[MSTS_EDGE_BIT]  <= ring_edge[c];
          end
        end
        if (addr == OFS_IRQ_STS) begin
          rd_data_r <= DATA_W'(irq_sts_r);
        end
        if (addr == OFS_IRQ_MSK) begin
          rd_data_r <= DATA_W'(irq_msk_r);
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_msts_ring_level: assert property (
    (rd_en && addr == OFS_MSTS[0]) |=> (rd_data[MSTS_RING_BIT] == $past(ring_in_ch0, 2)))
    else $error("status ring bit does not show ring level");

  a_ring_irq: assert property (
    (ier_r[0].modem_st && ring_edge[0]) |=> serial_irq_ch0)
    else $error("enabled ring edge did not raise channel interrupt");

  a_reset_state: assert property (
    $rose(nrst) |-> (send_request_ch0_n && send_request_ch1_n && !irq && irq_sts_r == IRQ_RST))
    else $error("state not cleared by reset");

  a_rts_active: assert property (
    (mctl_r[1].rts && !mctl_r[1].loop && !(mctl_r[1].auto_rts && rx_side_ch1.thresh_hit))
      |=> !send_request_ch1_n)
    else $error("send request not active with control bit set");

  a_rts_inactive: assert property (
    (!mctl_r[0].rts || mctl_r[0].loop) |=> send_request_ch0_n)
    else $error("send request active while cleared or in loopback");

  a_auto_rts: assert property (
    (mctl_r[0].auto_rts && rx_side_ch0.thresh_hit) |=> send_request_ch0_n)
    else $error("threshold logic did not force send request inactive");

  a_compat_mode0: assert property (
    (!fcr_r[1].fifo_en && fcr_r[1].dma_mode) |=> (rx_dma_ready_ch1_n == $past(rx_side_ch1.rx_empty)))
    else $error("compatibility mode not using mode 0 ready");

  a_irq_sources: assert property (
    (ier_r[1].tx_empty && rx_side_ch1.thr_empty) |=> serial_irq_ch1)
    else $error("enabled transmit empty did not raise interrupt");

  a_chan_isolated: assert property (
    (wr_en && addr == OFS_MCTL[1]) |=> $stable(mctl_r[0]))
    else $error("channel 1 write disturbed channel 0 control");

  a_sticky_level: assert property (
    (irq_sts_r & irq_msk_r) != '0 |=> irq)
    else $error("unmasked sticky status did not raise interrupt");

endmodule : urm_serial_sig
`default_nettype wire

// ### include/urm_pkg.sv
// Package: register map, field layouts and carriers of the serial signalling block
//
// Behaviour
// - Modem status bit 6 shows the current ring input level of the channel.
// - Modem status bit 2 sets when ring input rose since the last status read.
// - Ring rise with modem-status interrupt enabled raises that channel's interrupt.
// - Reset clears every internal register of both channels.
// - Send request output goes low when software sets the control request bit.
// - Send request is high on reset, in loopback, or when control bit 1 clears.
// - Auto mode: receive threshold logic forces send request high regardless of software.
// - With FIFO enabled, FIFO control bit 3 picks receive DMA mode 0 or 1.
// - Without FIFO only DMA mode 0 is used, whatever the mode bit says.
// - Mode 0: receive ready low while at least one character is held.
// - Mode 0: receive ready returns high once no characters remain.
// - Mode 1: receive ready goes low on trigger level or character timeout.
// - Mode 1: once low, receive ready stays low until receive side fully empty.
// - Channel interrupt is high for enabled error, data, transmit empty or modem change.
package urm_pkg;

  localparam int NUM_CH = 2;
  localparam int REG_W  = 8;
  localparam int ADR_W  = 4;

  // Per-channel register offsets
  localparam logic [ADR_W-1:0] OFS_MCTL [NUM_CH] = '{4'h0, 4'h4};
  localparam logic [ADR_W-1:0] OFS_FCR  [NUM_CH] = '{4'h1, 4'h5};
  localparam logic [ADR_W-1:0] OFS_MSTS [NUM_CH] = '{4'h2, 4'h6};
  localparam logic [ADR_W-1:0] OFS_IER  [NUM_CH] = '{4'h3, 4'h7};
  // Shared interrupt registers
  localparam logic [ADR_W-1:0] OFS_IRQ_STS = 4'h8;
  localparam logic [ADR_W-1:0] OFS_IRQ_MSK = 4'h9;

  // Modem status bit positions
  localparam int MSTS_EDGE_BIT = 2;
  localparam int MSTS_RING_BIT = 6;

  // Sticky status layout: ring rise per channel, then ready activation per channel
  localparam int IRQ_W        = 2 * NUM_CH;
  localparam int IRQ_RING_POS = 0;
  localparam int IRQ_RDY_POS  = NUM_CH;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic       auto_rts;
    logic       loop;
    logic [1:0] rsv_mid;
    logic       rts;
    logic       rsv_lo;
  } urm_mctl_type;

  typedef struct packed {
    logic [3:0] rsv_hi;
    logic       dma_mode;
    logic [1:0] rsv_mid;
    logic       fifo_en;
  } urm_fcr_type;

  typedef struct packed {
    logic [3:0] rsv;
    logic       modem_st;
    logic       line_st;
    logic       tx_empty;
    logic       rx_data;
  } urm_ier_type;

  // Receive and transmit side state of one channel
  typedef struct packed {
    logic rx_empty;
    logic trig_hit;
    logic timeout;
    logic thresh_hit;
    logic rx_error;
    logic data_avail;
    logic thr_empty;
  } urm_rx_side_type;

  localparam urm_mctl_type     MCTL_RST = 8'h00;
  localparam urm_fcr_type      FCR_RST  = 8'h00;
  localparam urm_ier_type      IER_RST  = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST  = 4'h0;

  typedef enum logic {
    RDY_IDLE = 1'b0,
    RDY_HOLD = 1'b1
  } urm_rdy_state_type;

endpackage : urm_pkg

// ### rtl/urm_ring_det.sv
// Ring input level capture and rising edge flag of one channel
`timescale 1ns/1ns
`default_nettype none
module urm_ring_det (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ring_in,
  input  wire logic status_rd,
  output logic      ring_lvl_r,
  output logic      edge_flag_r,
  output logic      rise_r
);
  import urm_pkg::*;

  logic rise;

  assign rise = ring_in & ~ring_lvl_r;

  // Level capture and edge pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ring_lvl_r <= 1'b0;
      rise_r     <= 1'b0;
    end else begin
      ring_lvl_r <= ring_in;
      rise_r     <= rise;
    end
  end

  // Set wins over read clear, so an edge in the read cycle survives
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      edge_flag_r <= 1'b0;
    end else begin
      edge_flag_r <= rise | (edge_flag_r & ~status_rd);
    end
  end

  a_edge_sets: assert property (@(posedge clk) disable iff (!nrst)
    (ring_in && !ring_lvl_r) |=> edge_flag_r)
    else $error("ring edge flag not set after rising edge");

  a_read_clears: assert property (@(posedge clk) disable iff (!nrst)
    (status_rd && !(ring_in && !ring_lvl_r)) |=> !edge_flag_r)
    else $error("ring edge flag not cleared by status read");

endmodule : urm_ring_det
`default_nettype wire

// ### rtl/urm_rx_ready.sv
// Receive DMA ready generator of one channel, modes 0 and 1
`timescale 1ns/1ns
`default_nettype none
module urm_rx_ready (
  input  wire logic            clk,
  input  wire logic            nrst,
  input  wire logic            fifo_en,
  input  wire logic            dma_mode,
  input  wire logic            rx_empty,
  input  wire logic            trig_hit,
  input  wire logic            timeout,
  output logic                 rdy_n_r,
  output logic                 went_active_r
);
  import urm_pkg::*;

  urm_rdy_state_type state_r;
  urm_rdy_state_type state_nxt;
  logic              multi;
  logic              rdy_n_nxt;

  // Mode 1 only when FIFO is on; compatibility mode forces mode 0
  assign multi = fifo_en & dma_mode;

  // Next state and output
  always_comb begin
    state_nxt = state_r;
    rdy_n_nxt = 1'b1;
    case (state_r)
      RDY_IDLE: begin
        if (multi && !rx_empty && (trig_hit || timeout)) begin
          state_nxt = RDY_HOLD;
        end
      end
      RDY_HOLD: begin
        if (rx_empty || !multi) begin
          state_nxt = RDY_IDLE;
        end
      end
      default: state_nxt = RDY_IDLE;
    endcase
    if (multi) begin
      rdy_n_nxt = (state_nxt == RDY_IDLE);
    end else begin
      rdy_n_nxt = rx_empty;
    end
  end

  // State, output and activation pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r       <= RDY_IDLE;
      rdy_n_r       <= 1'b1;
      went_active_r <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      rdy_n_r       <= rdy_n_nxt;
      went_active_r <= rdy_n_r & ~rdy_n_nxt;
    end
  end

  a_mode0_follow: assert property (@(posedge clk) disable iff (!nrst)
    !multi |=> (rdy_n_r == $past(rx_empty)))
    else $error("mode 0 ready does not follow receive occupancy");

  a_mode1_start: assert property (@(posedge clk) disable iff (!nrst)
    (multi && !rx_empty && (trig_hit || timeout)) |=> !rdy_n_r)
    else $error("mode 1 ready not active on trigger or timeout");

  a_mode1_hold: assert property (@(posedge clk) disable iff (!nrst)
    (multi && state_r == RDY_HOLD && !rx_empty) |=> !rdy_n_r)
    else $error("mode 1 ready released before receive side empty");

endmodule : urm_rx_ready
`default_nettype wire

// ### bench/urm_rx_partner.sv
// Receive path and DMA controller model at the far side of one channel
`timescale 1ns/1ns
`default_nettype none
module urm_rx_partner #(
  parameter int TRIG_LVL   = 4,
  parameter int THRESH_LVL = 6
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 push,
  input  wire logic                 tmo,
  input  wire logic [2:0]           flags,
  input  wire logic                 dma_en,
  input  wire logic                 rdy_n,
  output var urm_pkg::urm_rx_side_type side,
  output var logic [7:0]            cnt
);
  import urm_pkg::*;
  // Held characters; the DMA takes one a clock while ready is low, back to back
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'(push) - 8'(dma_en && !rdy_n && cnt != 8'h00);
    end
  end
  // Fill levels only; a timeout is whatever the bench pulses, even when empty
  assign side = '{rx_empty: cnt == 8'h00, trig_hit: 32'(cnt) >= TRIG_LVL, timeout: tmo,
                  thresh_hit: 32'(cnt) >= THRESH_LVL, rx_error: flags[2], data_avail: flags[1],
                  thr_empty: flags[0]};
endmodule : urm_rx_partner
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench of the dual-channel ready, send request and ring status block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import urm_pkg::*;
  localparam int TRIG_LVL   = 4;
  localparam int THRESH_LVL = 6;
  logic             clk;
  logic             nrst;
  logic [ADR_W-1:0] addr;
  logic [7:0]       wr_data;
  logic             wr_en;
  logic             rd_en;
  wire logic [7:0]  rd_data;
  logic [1:0]       ring;
  logic [1:0]       push;
  logic [1:0]       tmo;
  logic [1:0]       dma_en;
  logic [2:0]       flags [2];
  wire urm_rx_side_type side [2];
  wire logic [7:0]  cnt [2];
  wire logic        rts_n0, rts_n1, rdy_n0, rdy_n1, sirq0, sirq1, irq;
  wire logic [1:0]  rts_n = {rts_n1, rts_n0};
  wire logic [1:0]  rdy_n = {rdy_n1, rdy_n0};
  wire logic [1:0]  sirq  = {sirq1, sirq0};
  logic [7:0]       mctl_m [2];
  logic [7:0]       fcr_m [2];
  logic [7:0]       ier_m [2];
  logic [1:0]       flag_m;
  logic [1:0]       sts_m;
  logic [1:0]       msk_m;
  logic             burst_watch = 1'b0;
  logic             burst_low = 1'b0;
  logic [7:0]       mctl_seq [5] = '{8'h02, 8'h12, 8'h22, 8'h22, 8'h00};
  logic [7:0]       fcr_seq [2] = '{8'h08, 8'h01};
  int               mismatches = 0;
  int               samples_checked = 0;
  int               seed = 83;

  urm_serial_sig urm_serial_sig_i (
    .clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .ring_in_ch0(ring[0]), .ring_in_ch1(ring[1]), .rx_side_ch0(side[0]),
    .rx_side_ch1(side[1]), .send_request_ch0_n(rts_n0), .send_request_ch1_n(rts_n1),
    .rx_dma_ready_ch0_n(rdy_n0), .rx_dma_ready_ch1_n(rdy_n1), .serial_irq_ch0(sirq0),
    .serial_irq_ch1(sirq1), .irq(irq));

  // One far side per channel, so the channels can be told apart
  for (genvar g = 0; g < 2; g++) begin : g_far
    urm_rx_partner #(.TRIG_LVL(TRIG_LVL), .THRESH_LVL(THRESH_LVL)) urm_rx_partner_i (
      .clk(clk), .nrst(nrst), .push(push[g]), .tmo(tmo[g]), .flags(flags[g]), .dma_en(dma_en[g]),
      .rdy_n(rdy_n[g]), .side(side[g]), .cnt(cnt[g]));
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Bus tasks start just after an edge and leave a gap so strobes never toggle twice at once
  task automatic wr(input logic [ADR_W-1:0] a, input logic [7:0] d);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd_chk(input logic [ADR_W-1:0] a, input logic [7:0] msk, input logic [7:0] exp);
    logic [7:0] d;
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
    check(d & msk, exp, "register read");
    @(posedge clk);
  endtask : rd_chk

  task automatic push_n(input int c, input int n);
    repeat (n) begin
      push[c] <= 1'b1;
      @(posedge clk);
    end
    push[c] <= 1'b0;
    @(posedge clk);
  endtask : push_n

  task automatic model_clear();
    mctl_m = '{8'h00, 8'h00};
    fcr_m  = '{8'h00, 8'h00};
    ier_m  = '{8'h00, 8'h00};
    flag_m = 2'b00;
    sts_m  = 2'b00;
    msk_m  = 2'b00;
  endtask : model_clear

  // Settle, then hold every output except read data against the model; ready only in mode 0
  task automatic check_all();
    repeat (5) @(posedge clk);
    #1;
    for (int c = 0; c < 2; c++) begin
      check(rts_n[c], !(mctl_m[c][1] && !mctl_m[c][4] && !(mctl_m[c][5] && cnt[c] >= THRESH_LVL)), "rts");
      if (!(fcr_m[c][0] && fcr_m[c][3])) check(rdy_n[c], cnt[c] == 8'h00, "ready mode 0");
      check(sirq[c], (ier_m[c][3] & flag_m[c]) | (ier_m[c][2] & flags[c][2]) | (ier_m[c][0] & flags[c][1])
            | (ier_m[c][1] & flags[c][0]), "channel irq");
    end
    check(irq, |(sts_m & msk_m), "block irq");
    @(posedge clk);
  endtask : check_all

  task automatic look_rdy(input int c, input logic exp);
    repeat (3) @(posedge clk);
    #1;
    check(rdy_n[c], exp, "receive ready");
    @(posedge clk);
  endtask : look_rdy

  // Once a burst has started, ready may not rise while characters remain
  always @(negedge clk) begin
    if (burst_watch && rdy_n[0] === 1'b0) burst_low <= 1'b1;
    if (burst_watch && burst_low && cnt[0] != 8'h00) check(rdy_n[0], 1'b0, "ready rose in burst");
  end

  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    nrst = 1'b0; addr = '0; wr_data = '0; wr_en = 1'b0; rd_en = 1'b0;
    ring = '0; push = '0; tmo = '0; dma_en = '0; flags = '{3'h0, 3'h0};
    model_clear();
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // Reset values, unmapped space ignored
    for (int c = 0; c < 2; c++) begin
      rd_chk(OFS_MCTL[c], 8'hFF, 8'h00);
      rd_chk(OFS_FCR[c], 8'hFF, 8'h00);
      rd_chk(OFS_IER[c], 8'hFF, 8'h00);
      rd_chk(OFS_MSTS[c], 8'hFF, 8'h00);
    end
    wr(4'hF, 8'hFF);
    rd_chk(4'hF, 8'hFF, 8'h00);
    check_all();
    // Send request: set, loopback, auto below and above threshold, clear
    for (int c = 0; c < 2; c++) begin
      foreach (mctl_seq[i]) begin
        wr(OFS_MCTL[c], mctl_seq[i]);
        mctl_m[c] = mctl_seq[i];
        if (i == 3) push_n(c, THRESH_LVL);
        rd_chk(OFS_MCTL[c], 8'hFF, mctl_seq[i]);
        check_all();
      end
      dma_en[c] <= 1'b1;
      check_all();
      dma_en[c] <= 1'b0;
    end
    // Both channels' ready went active once, each in its own status bit
    rd_chk(OFS_IRQ_STS, 8'h0C, 8'h0C);
    // Ring rise, masked and unmasked, read clears the edge flag, then W1C
    wr(OFS_IRQ_MSK, 8'h01);
    msk_m = 2'b01;
    wr(OFS_IER[0], 8'h08);
    ier_m[0] = 8'h08;
    ring[0] <= 1'b1;
    flag_m[0] = 1'b1;
    sts_m[0] = 1'b1;
    check_all();
    rd_chk(OFS_IRQ_STS, 8'h03, 8'h01);
    rd_chk(OFS_MSTS[1], 8'hFF, 8'h00);
    rd_chk(OFS_MSTS[0], 8'hFF, 8'h44);
    flag_m[0] = 1'b0;
    rd_chk(OFS_MSTS[0], 8'hFF, 8'h40);
    wr(OFS_IRQ_STS, 8'h01);
    sts_m = 2'b00;
    wr(OFS_IRQ_MSK, 8'h00);
    msk_m = 2'b00;
    ring[0] <= 1'b0;
    check_all();
    ring[0] <= 1'b1;
    flag_m[0] = 1'b1;
    sts_m[0] = 1'b1;
    check_all();
    rd_chk(OFS_MSTS[0], 8'hFF, 8'h44);
    flag_m[0] = 1'b0;
    ring[0] <= 1'b0;
    wr(OFS_IRQ_STS, 8'h01);
    sts_m = 2'b00;
    rd_chk(OFS_IRQ_STS, 8'h03, 8'h00);
    // Random enables and receive flags on both channels
    repeat (8) begin
      for (int c = 0; c < 2; c++) begin
        ier_m[c] = 8'($random(seed)) & 8'h0F;
        flags[c] <= 3'($random(seed));
        wr(OFS_IER[c], ier_m[c]);
      end
      check_all();
    end
    // Mode 0 with the FIFO off and mode bit set, and with the FIFO on and mode bit clear
    foreach (fcr_seq[i]) begin
      wr(OFS_FCR[1], fcr_seq[i]);
      fcr_m[1] = fcr_seq[i];
      push_n(1, 2);
      check_all();
      dma_en[1] <= 1'b1;
      check_all();
      dma_en[1] <= 1'b0;
    end
    // Mode 1: empty timeout refused, below trigger idle, trigger burst runs to empty
    wr(OFS_FCR[0], 8'h09);
    fcr_m[0] = 8'h09;
    tmo[0] <= 1'b1;
    @(posedge clk);
    tmo[0] <= 1'b0;
    look_rdy(0, 1'b1);
    push_n(0, TRIG_LVL - 1);
    look_rdy(0, 1'b1);
    dma_en[0] <= 1'b1;
    burst_watch = 1'b1;
    push_n(0, 1);
    for (int k = 0; k < 40 && !(cnt[0] == 8'h00 && rdy_n[0] === 1'b1); k++) @(negedge clk);
    @(posedge clk);
    burst_watch = 1'b0;
    check(burst_low, 1'b1, "burst start");
    check(cnt[0], 8'h00, "burst drain");
    look_rdy(0, 1'b1);
    dma_en[0] <= 1'b0;
    push_n(0, 1);
    tmo[0] <= 1'b1;
    @(posedge clk);
    tmo[0] <= 1'b0;
    look_rdy(0, 1'b0);
    dma_en[0] <= 1'b1;
    look_rdy(0, 1'b1);
    // Reset in mid-run with both send requests active
    wr(OFS_MCTL[0], 8'h02);
    wr(OFS_MCTL[1], 8'h02);
    // Output launched at this very edge; look once it has settled
    #1;
    check(rts_n, 2'b00, "rts set");
    @(posedge clk);
    push_n(1, 1);
    nrst <= 1'b0;
    model_clear();
    #1;
    check({rts_n, rdy_n, sirq, irq}, 7'h78, "outputs in reset");
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_chk(OFS_MCTL[0], 8'hFF, 8'h00);
    check_all();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
